// *** hdl/pmcss_pkg.sv ***
/*
 * Shared constants of the clock select and status block: register offsets,
 * field positions, flag bit positions, reset values and timing factors.
 * Assumes a 32-bit APB register bus with byte addresses in the low bits.
 */
package pmcss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam int unsigned ADDR_W            = 8;
  localparam logic [7:0]  OFF_OSC_CONFIG    = 8'h20;
  localparam logic [7:0]  OFF_PLL_A_CONFIG  = 8'h28;
  localparam logic [7:0]  OFF_PLL_B_CONFIG  = 8'h2c;
  localparam logic [7:0]  OFF_MASTER_CONFIG = 8'h30;
  localparam logic [7:0]  OFF_PROG0_CONFIG  = 8'h40;
  localparam logic [7:0]  OFF_IRQ_ENABLE    = 8'h60;
  localparam logic [7:0]  OFF_IRQ_DISABLE   = 8'h64;
  localparam logic [7:0]  OFF_STATUS        = 8'h68;
  localparam logic [7:0]  OFF_IRQ_MASK      = 8'h6c;
  localparam logic [7:0]  OFF_EVENT         = 8'h70;
  localparam logic [7:0]  OFF_EVENT_CLEAR   = 8'h74;
  localparam logic [7:0]  PROG_STRIDE       = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions of the clock configuration words.
  localparam int unsigned SEL_LSB   = 0;
  localparam int unsigned SEL_W     = 2;
  localparam int unsigned CLOCK_PRESCALER_LSB  = 2;
  localparam int unsigned CLOCK_PRESCALER_W    = 3;
  localparam int unsigned RATIO_LSB = 8;
  localparam int unsigned RATIO_W   = 2;
  localparam logic [2:0]  CLOCK_PRESCALER_RESERVED = 3'h7;

  // Oscillator and PLL configuration fields.
  localparam int unsigned OSC_EN_BIT     = 0;
  localparam int unsigned OSC_BYPASS_BIT = 1;
  localparam int unsigned OSC_COUNT_LSB  = 8;
  localparam int unsigned OSC_COUNT_W    = 8;
  localparam int unsigned OSC_COUNT_MULT = 8;
  localparam int unsigned PLL_COUNT_LSB  = 8;
  localparam int unsigned PLL_COUNT_W    = 6;
  localparam int unsigned USB_HALVE_BIT  = 28;

  ////////////////////////////////////////////////////////////////////////////
  // Flag layout shared by status, enable, disable, mask and event words.
  localparam int unsigned FLAG_W         = 12;
  localparam int unsigned FLAG_OSC       = 0;
  localparam int unsigned FLAG_PLL_A     = 1;
  localparam int unsigned FLAG_PLL_B     = 2;
  localparam int unsigned FLAG_MASTER    = 3;
  localparam int unsigned FLAG_PROG0     = 8;
  localparam logic [11:0] FLAG_VALID     = 12'hf0f;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [1:0]  RST_SEL        = 2'h0;
  localparam logic [2:0]  RST_CLOCK_PRESCALER       = 3'h0;
  localparam logic [1:0]  RST_RATIO      = 2'h0;
  localparam logic [7:0]  RST_OSC_COUNT  = 8'h00;
  localparam logic [5:0]  RST_PLL_COUNT  = 6'h00;
  localparam logic [11:0] RST_IRQ_ENABLE = 12'h000;

endpackage

// *** hdl/pmcss_clk_gen.sv ***
/*
 * One clock generator: picks one of four synchronised source clocks,
 * divides it by a power of two and switches configuration without glitches.
 * Assumes source levels and rising-edge pulses already sit in pclk domain.
 */
`timescale 1ns/1ps
module pmcss_clk_gen
  import pmcss_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  src_level,
  input  wire logic [3:0]  src_edge,
  input  wire logic        apply,
  input  wire logic [1:0]  new_sel,
  input  wire logic [2:0]  new_clock_prescaler,
  output logic             clk_q,
  output logic             ready_q
);

  typedef enum logic {PMCSS_RUN, PMCSS_SWITCH} pmcss_gen_e;

  pmcss_gen_e state_q;     // Running or waiting for a safe switch point.
  logic [1:0] sel_q;       // Source in use.
  logic [2:0] clock_prescaler_q;      // Prescaler in use.
  logic [1:0] pend_sel_q;  // Source waiting to be applied.
  logic [2:0] pend_clock_prescaler_q; // Prescaler waiting to be applied.
  logic [5:0] cnt_q;       // Source edges seen in the current half period.

  // Last edge count of a half period for prescaler codes 1 to 6.
  function automatic logic [5:0] half_last(input logic [2:0] clock_prescaler);
    logic [6:0] half;
    half = 7'h01 << (clock_prescaler - 3'h1);
    return 6'(half - 7'h01);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Output divider. While a switch is pending the output runs on until it is
  // low and is then parked low, so the new setting always starts from a clean
  // low phase and no runt pulse can reach the clock net.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
      cnt_q <= 6'h00;
    end else if (state_q == PMCSS_SWITCH && !clk_q) begin
      clk_q <= 1'b0;
      cnt_q <= 6'h00;
    end else if (clock_prescaler_q == CLOCK_PRESCALER_RESERVED) begin
      // Reserved code stops the clock low.
      clk_q <= 1'b0;
    end else if (clock_prescaler_q == 3'h0) begin
      // Undivided: follow the chosen source.
      clk_q <= src_level[sel_q];
    end else if (src_edge[sel_q]) begin
      if (cnt_q == half_last(clock_prescaler_q)) begin
        cnt_q <= 6'h00;
        clk_q <= ~clk_q;
      end else begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and ready flag. A new request during a pending switch
  // simply replaces the pending setting. Limitation: if the old source has
  // stopped while the output is high, the switch waits for it forever.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= PMCSS_RUN;
      sel_q       <= RST_SEL;
      clock_prescaler_q      <= RST_CLOCK_PRESCALER;
      pend_sel_q  <= RST_SEL;
      pend_clock_prescaler_q <= RST_CLOCK_PRESCALER;
      ready_q     <= 1'b1;
    end else if (apply) begin
      state_q     <= PMCSS_SWITCH;
      pend_sel_q  <= new_sel;
      pend_clock_prescaler_q <= new_clock_prescaler;
      ready_q     <= 1'b0;
    end else begin
      case (state_q)
        PMCSS_SWITCH: begin
          if (!clk_q) begin
            sel_q   <= pend_sel_q;
            clock_prescaler_q  <= pend_clock_prescaler_q;
            state_q <= PMCSS_RUN;
            ready_q <= 1'b1;
          end
        end
        default: begin
          state_q <= PMCSS_RUN;
        end
      endcase
    end
  end

endmodule

// *** hdl/pmcss_top.sv ***
/*
 * Clock select and status block: master clock selector with prescaler and
 * processor ratio, four programmable clocks, USB clock halving, oscillator
 * and PLL ready timing, and the interrupt enable, mask and status logic.
 * Assumes source clocks arrive unsynchronised and run below pclk / 2.
 */
// Behaviour
// - USB clock is PLL B, or PLL B halved
// - Source select: slow, main, PLL A, PLL B
// - Prescaler divides by 1 to 64, 7 reserved
// - Processor clock 1 to 4 times master
// - Four programmable clocks, own source and prescaler
// - Enable register sets interrupt enables by ones
// - Disable register clears interrupt enables by ones
// - Status bit 0 shows oscillator stable
// - Status bit 3 shows master clock ready
// - Status bits 8 to 11 show programmable ready
// - Mask register reads 0 enabled, 1 disabled
// - PLL A locks after programmed slow cycles
// - Oscillator stable after 8 times count cycles
`timescale 1ns/1ps
module pmcss_top
  import pmcss_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata_q,
  output logic                   pready_q,
  output logic                   pslverr_q,
  input  wire logic              slow_clk,
  input  wire logic              main_clk,
  input  wire logic              pll_a_clk,
  input  wire logic              pll_b_clk,
  output logic                   processor_clock_q,
  output logic                   master_clock_q,
  output logic      [3:0]        prog_clock_q,
  output logic                   usb_clock_q,
  output logic                   irq_q
);

  localparam int unsigned PROG_N = 4;
  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [3:0]       src_meta_q;      // First synchroniser stage.
  logic [3:0]       src_sync_q;      // Second stage, safe to read.
  logic [3:0]       src_prev_q;      // Previous level for edge detection.
  logic [3:0]       src_edge;        // One-cycle pulse per source edge.
  logic             wr_en;           // Write completes this edge.
  logic             setup;           // Setup phase of any transfer.
  logic [1:0]       mck_sel_q;       // Master source select.
  logic [2:0]       mck_clock_prescaler_q;      // Master prescaler.
  logic [1:0]       ratio_q;         // Processor to master ratio code.
  logic [4:0]       pck_cfg_q [PROG_N]; // Programmable clock words.
  logic             osc_en_q;        // Main oscillator enabled.
  logic             osc_byp_q;       // Main oscillator bypassed.
  logic [7:0]       osc_count_q;     // Start-up count in units of eight.
  logic [10:0]      osc_cnt_q;       // Start-up slow edges still to wait.
  logic             osc_run_q;       // Start-up timer active.
  logic             osc_stable_q;    // Oscillator stable flag.
  logic [5:0]       pll_count_q [2]; // Programmed lock counts.
  logic [5:0]       pll_cnt_q [2];   // Lock slow edges still to wait.
  logic [1:0]       pll_run_q;       // Lock timers active.
  logic [1:0]       pll_lock_q;      // Lock flags, A then B.
  logic             usb_halve_q;     // USB clock halving option.
  logic [FLAG_W-1:0] irq_en_q;       // Interrupt enables.
  logic [FLAG_W-1:0] evt_q;          // Sticky rising-flag events.
  logic [FLAG_W-1:0] flag_prev_q;    // Flags one cycle ago.
  logic [FLAG_W-1:0] status;         // Live flag word.
  logic             mck_ready;       // Master clock generator ready.
  logic [PROG_N-1:0] pck_ready;      // Programmable generators ready.
  logic             proc_prev_q;     // Processor clock one cycle ago.
  logic [1:0]       ratio_cnt_q;     // Processor edges in master period.
  logic [31:0]      rdata_d;         // Read data of the addressed word.
  logic             err_d;           // Address maps to no register.

  // Address match helper shared by the write and read decoders.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        off);
    return a == off;
  endfunction

  // Offset of programmable clock word i.
  function automatic logic [7:0] prog_off(input int unsigned i);
    return 8'(OFF_PROG0_CONFIG + 8'(i) * PROG_STRIDE);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Source clock synchronisers. Only the second stage feeds any logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_meta_q <= 4'h0;
      src_sync_q <= 4'h0;
      src_prev_q <= 4'h0;
    end else begin
      src_meta_q <= {pll_b_clk, pll_a_clk, main_clk, slow_clk};
      src_sync_q <= src_meta_q;
      src_prev_q <= src_sync_q;
    end
  end

  assign src_edge = src_sync_q & ~src_prev_q;
  ////////////////////////////////////////////////////////////////////////////
  // APB slave handshake. Answers are registered in the setup phase so that
  // pready is high in the first access cycle: no wait states.
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= err_d;
        prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Master clock word. Every write starts a switch, including one that
  // repeats the present value, which software is expected not to issue.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mck_sel_q  <= RST_SEL;
      mck_clock_prescaler_q <= RST_CLOCK_PRESCALER;
      ratio_q    <= RST_RATIO;
    end else if (wr_en && hit(paddr, OFF_MASTER_CONFIG)) begin
      mck_sel_q  <= pwdata[SEL_LSB +: SEL_W];
      mck_clock_prescaler_q <= pwdata[CLOCK_PRESCALER_LSB +: CLOCK_PRESCALER_W];
      ratio_q    <= pwdata[RATIO_LSB +: RATIO_W];
    end
  end

  // Processor clock generator: selected source after the prescaler.
  pmcss_clk_gen u_proc_gen (
    .pclk      (pclk),
    .presetn   (presetn),
    .src_level (src_sync_q),
    .src_edge  (src_edge),
    .apply     (wr_en && hit(paddr, OFF_MASTER_CONFIG)),
    .new_sel   (pwdata[SEL_LSB +: SEL_W]),
    .new_clock_prescaler  (pwdata[CLOCK_PRESCALER_LSB +: CLOCK_PRESCALER_W]),
    .clk_q     (processor_clock_q),
    .ready_q   (mck_ready)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Master clock is the processor clock divided by ratio code plus one.
  // A ratio of three gives an uneven duty cycle; only the rising edges matter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proc_prev_q    <= 1'b0;
      ratio_cnt_q    <= 2'h0;
      master_clock_q <= 1'b0;
    end else begin
      proc_prev_q <= processor_clock_q;
      if (ratio_q == 2'h0) begin
        ratio_cnt_q    <= 2'h0;
        master_clock_q <= processor_clock_q;
      end else if (processor_clock_q && !proc_prev_q) begin
        if (ratio_cnt_q >= ratio_q) begin
          ratio_cnt_q    <= 2'h0;
          master_clock_q <= 1'b1;
        end else begin
          ratio_cnt_q    <= ratio_cnt_q + 2'h1;
          master_clock_q <= ({1'b0, ratio_cnt_q} + 3'h1) <
                            ((3'({1'b0, ratio_q}) + 3'h2) >> 1);
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Programmable clocks, each with its own word and generator.
  generate
    for (genvar i = 0; i < PROG_N; i++) begin : g_prog
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pck_cfg_q[i] <= {RST_CLOCK_PRESCALER, RST_SEL};
        end else if (wr_en && hit(paddr, prog_off(i))) begin
          pck_cfg_q[i] <= pwdata[4:0];
        end
      end

      pmcss_clk_gen u_prog_gen (
        .pclk      (pclk),
        .presetn   (presetn),
        .src_level (src_sync_q),
        .src_edge  (src_edge),
        .apply     (wr_en && hit(paddr, prog_off(i))),
        .new_sel   (pwdata[SEL_LSB +: SEL_W]),
        .new_clock_prescaler  (pwdata[CLOCK_PRESCALER_LSB +: CLOCK_PRESCALER_W]),
        .clk_q     (prog_clock_q[i]),
        .ready_q   (pck_ready[i])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // Main oscillator start-up timer on slow clock edges. Bypass sets the
  // flag at once; clearing both enable and bypass drops it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_q     <= 1'b0;
      osc_byp_q    <= 1'b0;
      osc_count_q  <= RST_OSC_COUNT;
      osc_cnt_q    <= 11'h000;
      osc_run_q    <= 1'b0;
      osc_stable_q <= 1'b0;
    end else if (wr_en && hit(paddr, OFF_OSC_CONFIG)) begin
      osc_en_q    <= pwdata[OSC_EN_BIT];
      osc_byp_q   <= pwdata[OSC_BYPASS_BIT];
      osc_count_q <= pwdata[OSC_COUNT_LSB +: OSC_COUNT_W];
      osc_cnt_q   <= 11'(pwdata[OSC_COUNT_LSB +: OSC_COUNT_W] *
                         OSC_COUNT_MULT);
      osc_run_q   <= pwdata[OSC_EN_BIT] & ~pwdata[OSC_BYPASS_BIT];
      // Bypass is stable at once; any other write drops the flag and restarts the wait only with enable set.
      osc_stable_q <= pwdata[OSC_BYPASS_BIT];
    end else if (osc_run_q) begin
      if (osc_cnt_q == 11'h000) begin
        osc_run_q    <= 1'b0;
        osc_stable_q <= 1'b1;
      end else if (src_edge[0]) begin
        osc_cnt_q <= osc_cnt_q - 11'h001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // PLL lock timers. A write to a PLL word drops its lock flag and counts
  // the programmed slow edges before raising it again.
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pll
      localparam logic [7:0] POFF = (p == 0) ? OFF_PLL_A_CONFIG
                                             : OFF_PLL_B_CONFIG;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pll_count_q[p] <= RST_PLL_COUNT;
          pll_cnt_q[p]   <= RST_PLL_COUNT;
          pll_run_q[p]   <= 1'b0;
          pll_lock_q[p]  <= 1'b0;
        end else if (wr_en && hit(paddr, POFF)) begin
          pll_count_q[p] <= pwdata[PLL_COUNT_LSB +: PLL_COUNT_W];
          pll_cnt_q[p]   <= pwdata[PLL_COUNT_LSB +: PLL_COUNT_W];
          pll_run_q[p]   <= 1'b1;
          pll_lock_q[p]  <= 1'b0;
        end else if (pll_run_q[p]) begin
          if (pll_cnt_q[p] == 6'h00) begin
            pll_run_q[p]  <= 1'b0;
            pll_lock_q[p] <= 1'b1;
          end else if (src_edge[0]) begin
            pll_cnt_q[p] <= pll_cnt_q[p] - 6'h01;
          end
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // USB clock: PLL B directly, or PLL B halved by toggling on its edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_halve_q <= 1'b0;
      usb_clock_q <= 1'b0;
    end else begin
      if (wr_en && hit(paddr, OFF_PLL_B_CONFIG)) begin
        usb_halve_q <= pwdata[USB_HALVE_BIT];
      end
      if (!usb_halve_q) begin
        usb_clock_q <= src_sync_q[3];
      end else if (src_edge[3]) begin
        usb_clock_q <= ~usb_clock_q;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Live status word.
  always_comb begin
    status                = '0;
    status[FLAG_OSC]      = osc_stable_q;
    status[FLAG_PLL_A]    = pll_lock_q[0];
    status[FLAG_PLL_B]    = pll_lock_q[1];
    status[FLAG_MASTER]   = mck_ready;
    status[FLAG_PROG0 +: PROG_N] = pck_ready;
  end

  // Interrupt enables: set by ones, cleared by ones; set wins on overlap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= RST_IRQ_ENABLE;
    end else if (wr_en && hit(paddr, OFF_IRQ_ENABLE)) begin
      irq_en_q <= irq_en_q | (pwdata[FLAG_W-1:0] & FLAG_VALID);
    end else if (wr_en && hit(paddr, OFF_IRQ_DISABLE)) begin
      irq_en_q <= irq_en_q & ~(pwdata[FLAG_W-1:0] & FLAG_VALID);
    end
  end

  // Sticky event bits catch each rising flag; a new event beats its clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_prev_q <= '0;
      evt_q       <= '0;
    end else begin
      flag_prev_q <= status;
      if (wr_en && hit(paddr, OFF_EVENT_CLEAR)) begin
        evt_q <= (evt_q & ~pwdata[FLAG_W-1:0]) | (status & ~flag_prev_q);
      end else begin
        evt_q <= evt_q | (status & ~flag_prev_q);
      end
    end
  end

  // Interrupt output follows live flags gated by their enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status & irq_en_q);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read decoder. Write-only words read as zero; unmapped offsets error.
  always_comb begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (hit(paddr, OFF_MASTER_CONFIG)) begin
      rdata_d[SEL_LSB +: SEL_W]     = mck_sel_q;
      rdata_d[CLOCK_PRESCALER_LSB +: CLOCK_PRESCALER_W]   = mck_clock_prescaler_q;
      rdata_d[RATIO_LSB +: RATIO_W] = ratio_q;
    end else if (hit(paddr, OFF_OSC_CONFIG)) begin
      rdata_d[OSC_EN_BIT]     = osc_en_q;
      rdata_d[OSC_BYPASS_BIT] = osc_byp_q;
      rdata_d[OSC_COUNT_LSB +: OSC_COUNT_W] = osc_count_q;
    end else if (hit(paddr, OFF_PLL_A_CONFIG)) begin
      rdata_d[PLL_COUNT_LSB +: PLL_COUNT_W] = pll_count_q[0];
    end else if (hit(paddr, OFF_PLL_B_CONFIG)) begin
      rdata_d[PLL_COUNT_LSB +: PLL_COUNT_W] = pll_count_q[1];
      rdata_d[USB_HALVE_BIT] = usb_halve_q;
    end else if (hit(paddr, OFF_STATUS)) begin
      rdata_d[FLAG_W-1:0] = status;
    end else if (hit(paddr, OFF_IRQ_MASK)) begin
      rdata_d[FLAG_W-1:0] = ~irq_en_q & FLAG_VALID;
    end else if (hit(paddr, OFF_EVENT)) begin
      rdata_d[FLAG_W-1:0] = evt_q;
    end else if (hit(paddr, OFF_IRQ_ENABLE) ||
                 hit(paddr, OFF_IRQ_DISABLE) ||
                 hit(paddr, OFF_EVENT_CLEAR)) begin
      rdata_d = 32'h0000_0000;
    end else begin
      err_d = 1'b1;
      for (int unsigned i = 0; i < PROG_N; i++) begin
        if (hit(paddr, prog_off(i))) begin
          rdata_d[4:0] = pck_cfg_q[i];
          err_d        = 1'b0;
        end
      end
    end
  end

endmodule

// *** verif/pmcss_sva.sv ***
/* Port checker of the clock select and status block.
   Assumes it is bound into pmcss_top and sees only its ports. */
`timescale 1ns/1ps
module pmcss_sva
  import pmcss_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata_q,
  input wire logic              pready_q,
  input wire logic              pslverr_q,
  input wire logic              irq_q
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A read that completes at this edge.
  logic rd;
  assign rd = psel && penable && pready_q && !pwrite;
  ////////////////////////////////////////////////////////////////////////////
  setup_ready_a: assert property (psel && !penable |=> pready_q)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_q |=> !pready_q)
    else $error("ready held too long");
  idle_ready_a: assert property (!psel |=> !pready_q)
    else $error("ready while idle");
  unmapped_err_a: assert property (rd && paddr == 8'h00 |->
    pslverr_q && prdata_q == 32'h0) else $error("unmapped read accepted");
  status_ok_a: assert property (rd && paddr == OFF_STATUS |-> !pslverr_q)
    else $error("status read refused");
  status_bits_a: assert property (rd && paddr == OFF_STATUS |->
    (prdata_q & ~{20'h0, FLAG_VALID}) == 32'h0) else $error("status bits");
  mask_bits_a: assert property (rd && paddr == OFF_IRQ_MASK |->
    (prdata_q & ~{20'h0, FLAG_VALID}) == 32'h0) else $error("mask bits");
  irq_off_a: assert property (rd && paddr == OFF_IRQ_MASK &&
    prdata_q[11:0] == 12'hf0f |=> !irq_q) else $error("irq while masked");
  cover property (rd && pslverr_q);
  cover property (irq_q);
  cover property (rd && paddr == OFF_IRQ_MASK);
endmodule

bind pmcss_top pmcss_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
  .irq_q(irq_q));

// *** verif/tb_top.sv ***
/* Bench of the clock select and status block: APB master, edge counters.
   Assumes pmcss_top with its bound checker; sources are free-running. */
`timescale 1ns/1ps
module tb_top
  import pmcss_pkg::*;
();
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready_q, pslverr_q, irq_q, usb_clock_q, er_v;
  logic [7:0]  paddr = 8'h00, mon, mon_q = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata_q, rd_v;
  logic        processor_clock_q, master_clock_q;
  logic [3:0]  prog_clock_q, src = 4'h0;
  int          cnt [8] = '{default: 0};
  int          per [4] = '{16, 10, 6, 8};
  int          errors = 0, tests_run = 0;
  pmcss_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .slow_clk(src[0]), .main_clk(src[1]), .pll_a_clk(src[2]),
    .pll_b_clk(src[3]), .processor_clock_q(processor_clock_q),
    .master_clock_q(master_clock_q), .prog_clock_q(prog_clock_q),
    .usb_clock_q(usb_clock_q), .irq_q(irq_q));
  always #5 pclk = ~pclk;
  always #80 src[0] = ~src[0];
  always #50 src[1] = ~src[1];
  always #30 src[2] = ~src[2];
  always #40 src[3] = ~src[3];
  assign mon = {prog_clock_q, usb_clock_q, master_clock_q,
                processor_clock_q, src[3]};
  // Rising edges of each watched clock, counted in pclk time.
  always @(posedge pclk) begin
    mon_q <= mon;
    for (int i = 0; i < 8; i++)
      if (mon[i] === 1'b1 && mon_q[i] === 1'b0) cnt[i]++;
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // Window edges make a count one off either way.
  task automatic near(input string n, input int e, s);
    tests_run++;
    if (s < e - 1 || s > e + 1) begin
      errors++;
      $display("wrong value %s exp %0d seen %0d", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do @(posedge pclk);
    while (pready_q !== 1'b1);
    rd_v = prdata_q;
    er_v = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd_v);
  endtask
  // Counting window of 960 cycles, cleared off the counting edge.
  task automatic win();
    @(negedge pclk);
    cnt = '{default: 0};
    repeat (960) @(negedge pclk);
  endtask
  task automatic give_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_irq();
    rdchk(OFF_STATUS, 32'hf08, "status");
    rdchk(OFF_IRQ_MASK, 32'hf0f, "mask");
    rdchk(8'h00, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, er_v});
    bus(1'b1, OFF_IRQ_ENABLE, 32'h8);
    bus(1'b1, OFF_IRQ_ENABLE, 32'h0);
    rdchk(OFF_IRQ_MASK, 32'hf07, "mask on");
    chk("irq on", 32'h1, {31'h0, irq_q});
    bus(1'b1, OFF_IRQ_DISABLE, 32'h0);
    rdchk(OFF_IRQ_MASK, 32'hf07, "mask kept");
    bus(1'b1, OFF_IRQ_DISABLE, 32'h8);
    rdchk(OFF_IRQ_MASK, 32'hf0f, "mask off");
    chk("irq off", 32'h0, {31'h0, irq_q});
  endtask
  // Start-up of 2 x 8 slow edges, then PLL locks and the USB divider.
  task automatic t_osc_pll();
    bus(1'b1, OFF_OSC_CONFIG, 32'h201);
    repeat (150) @(posedge pclk);
    rdchk(OFF_STATUS, 32'hf08, "osc early");
    repeat (200) @(posedge pclk);
    rdchk(OFF_STATUS, 32'hf09, "osc late");
    bus(1'b1, OFF_PLL_A_CONFIG, 32'h400);
    rdchk(OFF_STATUS, 32'hf09, "pll a early");
    repeat (100) @(posedge pclk);
    rdchk(OFF_STATUS, 32'hf0b, "pll a late");
    for (int h = 1; h >= 0; h--) begin
      bus(1'b1, OFF_PLL_B_CONFIG, 32'(h) << USB_HALVE_BIT);
      repeat (20) @(posedge pclk);
      rdchk(OFF_STATUS, 32'hf0f, "pll b");
      win();
      near("usb edges", cnt[0] / (h + 1), cnt[3]);
    end
  endtask
  task automatic t_clocks();
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFF_MASTER_CONFIG, 32'(i * 256 + ((i + 1) % 2) * 4 + i));
      repeat (100) @(posedge pclk);
      rdchk(OFF_STATUS, 32'hf0f, "master ready");
      win();
      near("proc", 960 / (per[i] * (1 + (i + 1) % 2)), cnt[1]);
      near("master", cnt[1] / (i + 1), cnt[2]);
    end
    bus(1'b1, OFF_MASTER_CONFIG, 32'h1f);
    win();
    near("reserved", 0, cnt[1]);
    for (int k = 0; k < 4; k++)
      bus(1'b1, OFF_PROG0_CONFIG + 8'(4 * k), 32'(4 + k));
    repeat (100) @(posedge pclk);
    rdchk(OFF_STATUS, 32'hf0f, "prog ready");
    win();
    for (int k = 0; k < 4; k++)
      near("prog", 960 / (per[k] * 2), cnt[4 + k]);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_irq();
    t_osc_pll();
    t_clocks();
    give_verdict();
  end
  initial begin
    #300000;
    errors++;
    give_verdict();
  end
endmodule
